// [plc_model.sv]
// controller model on the shared word port
`timescale 1ns/10ps
module plc_model
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [1:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  // idle bus at time zero
  initial
  begin
    o_addr = 2'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle write; released data is inverted so nothing relies on it
  task automatic write_word(input logic [1:0] a, input logic [15:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
    // return off the edge so a following call never re-drives the strobe in this step
    #1;
  endtask : write_word
  // one-cycle read, answer taken in the following cycle
  task automatic read_word(input logic [1:0] a, output logic [15:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask : read_word
  // weight then status; a pair flagged in progress is thrown away, except on the fourth try, which is kept
  task automatic read_pair(output logic [15:0] w, output logic [15:0] s);
    for (int n = 0; n < 4; n++)
    begin
      read_word(2'h0, w);
      read_word(2'h1, s);
      if (!s[14])
        break;
    end
  endtask : read_pair
endmodule : plc_model

// [scale_xchg.sv]
// per-scale discrete exchange between weighing terminal and controller
`timescale 1ns/10ps
`include "scale_xchg_cfg.svh"
module scale_xchg
(
  input wire logic i_clk,
  input wire logic i_reset,
  // controller side shared word port
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // terminal side: refresh request and weights
  input wire logic i_refresh,
  input wire logic [15:0] i_gross,
  input wire logic [15:0] i_net,
  input wire logic [15:0] i_displayed,
  input wire logic [15:0] i_tare,
  input wire logic [15:0] i_target,
  input wire logic [15:0] i_setpoint1,
  // terminal side: scale state
  input wire logic i_scale_normal,
  input wire logic i_over_range,
  input wire logic i_under_range,
  input wire logic i_power_up,
  input wire logic i_expanded,
  input wire logic i_setup,
  input wire logic i_motion,
  input wire logic i_net_mode,
  input wire logic i_overunder_mode,
  input wire logic i_indicator_mode,
  input wire logic i_tare_interlock,
  input wire logic i_tare_active,
  input wire logic i_gross_zero,
  // terminal side: setpoint and comparator indications
  input wire logic i_sp1_out,
  input wire logic i_sp2_out,
  input wire logic i_ztol_out,
  input wire logic i_under_ind,
  input wire logic i_ok_ind,
  input wire logic i_over_ind,
  // parallel input pin, asynchronous
  input wire logic i_parallel_input_state,
  // commands toward the terminal
  output logic o_preset_tare_load,
  output logic [15:0] o_preset_tare,
  output logic o_clear_tare,
  output logic o_pb_tare,
  output logic o_print,
  output logic o_zero,
  output logic o_setpoint_enable,
  output logic o_sp1_load,
  output logic [15:0] o_sp1_value,
  output logic o_nv_store,
  output logic o_parallel_output_one,
  output logic o_parallel_output_two,
  output logic o_parallel_output_three
);
  // ************************************
  // helpers
  // ************************************
  // weight source decode, codes 5-7 fall back to gross
  function automatic logic [15:0] pick_weight
  (
    input logic [2:0] sel,
    input logic [15:0] gross,
    input logic [15:0] net,
    input logic [15:0] disp,
    input logic [15:0] tare_or_target,
    input logic [15:0] sp1
  );
    logic [15:0] w;
    w = gross;
    case (sel)
      `SEL_NET: w = net;
      `SEL_DISP: w = disp;
      `SEL_TARE: w = tare_or_target;
      `SEL_SP1: w = sp1;
      default: w = gross;
    endcase
    return w;
  endfunction : pick_weight

  // ************************************
  // declarations
  // ************************************
  shared_mem_if mbus ();
  scale_xchg_pkg::refresh_state_t ref_state_r; // refresh sequencer
  scale_xchg_pkg::refresh_state_t ref_state_nxt;
  logic par_meta_r; // first synchroniser stage
  logic par_sync_r; // synchronised parallel input
  logic [15:0] cmd_r; // last latched command word
  logic [15:0] value_r; // last latched value word
  logic [15:0] cmd_rise; // bits going 0 to 1 on this write
  logic cmd_wr; // command word write this cycle
  logic val_wr; // value word write this cycle
  logic [15:0] value_now; // value as seen by this command
  logic sp_pending_r; // setpoint downloaded, not yet committed
  logic uip_r; // sticky update-in-progress flag
  logic rd0_seen_r; // weight read, status read still due
  logic busy; // rewrite of input words under way
  logic data_ok; // scale in normal operation
  logic [15:0] weight_word; // weight as reported
  logic [15:0] status_word; // status as reported
  logic [15:0] status_latch_r; // status taken at refresh start
  logic [15:0] weight_latch_r; // weight taken at refresh start
  logic [15:0] tare_or_target;
  logic sp1_bit;
  logic sp2_bit;
  logic ztol_bit;
  logic tare_ok; // tare request allowed
  logic clear_ok; // clear-tare request allowed

  shared_word_mem u_mem
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .bus(mbus.mem)
  );

  // ************************************
  // parallel input synchroniser
  // ************************************
  // two stages; only the second stage is read
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      par_meta_r <= 1'b0;
      par_sync_r <= 1'b0;
    end
    else
    begin
      par_meta_r <= i_parallel_input_state;
      par_sync_r <= par_meta_r;
    end
  end

  // ************************************
  // command word edge detection
  // ************************************
  assign cmd_wr = i_wr && i_addr == `XCHG_ADDR_CMD;
  assign val_wr = i_wr && i_addr == `XCHG_ADDR_VALUE;
  // rising bits against the previous latched word, one shot per change
  assign cmd_rise = cmd_wr ? (i_wdata & ~cmd_r) : 16'h0000; // R22
  assign value_now = value_r; // R9

  // latch the controller's words; bits 9-11 are stored but never used
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cmd_r <= `WORD_RESET;
      value_r <= `WORD_RESET;
    end
    else
    begin
      if (cmd_wr)
        cmd_r <= i_wdata; // R22 R21
      if (val_wr)
        value_r <= i_wdata; // R1
    end
  end

  // ************************************
  // tare interlock checks
  // ************************************
  // with interlocks on, tares never stack and clears need gross zero
  assign tare_ok = !i_tare_interlock || !i_tare_active; // R19
  assign clear_ok = !i_tare_interlock || i_gross_zero; // R20

  // ************************************
  // command pulses
  // ************************************
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_preset_tare_load <= 1'b0;
      o_preset_tare <= `WORD_RESET;
      o_clear_tare <= 1'b0;
      o_pb_tare <= 1'b0;
      o_print <= 1'b0;
      o_zero <= 1'b0;
    end
    else
    begin
      o_preset_tare_load <= cmd_rise[`CMD_PRESET] && tare_ok; // R11 R19
      if (cmd_rise[`CMD_PRESET] && tare_ok)
        o_preset_tare <= value_now; // R11
      o_clear_tare <= cmd_rise[`CMD_CLR_TARE] && clear_ok; // R12 R20
      o_pb_tare <= cmd_rise[`CMD_PB_TARE] && tare_ok; // R12 R19
      o_print <= cmd_rise[`CMD_PRINT]; // R12
      o_zero <= cmd_rise[`CMD_ZERO]; // R12
    end
  end

  // ************************************
  // setpoint load, enable and commit
  // ************************************
  // value is taken as is, in the calibrated unit; no conversion here
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_sp1_load <= 1'b0;
      o_sp1_value <= `WORD_RESET;
      o_setpoint_enable <= 1'b0;
      o_nv_store <= 1'b0;
      sp_pending_r <= 1'b0;
    end
    else
    begin
      o_sp1_load <= cmd_rise[`CMD_LOAD_SP1]; // R15
      if (cmd_rise[`CMD_LOAD_SP1])
        o_sp1_value <= value_now; // R15 R16
      if (cmd_wr)
        o_setpoint_enable <= i_wdata[`CMD_SP_EN]; // R13
      // commit at once when enabled, else hold until enable rises
      if (cmd_rise[`CMD_LOAD_SP1] && i_wdata[`CMD_SP_EN])
      begin
        o_nv_store <= 1'b1; // R15
        sp_pending_r <= 1'b0;
      end
      else if (cmd_rise[`CMD_LOAD_SP1])
      begin
        o_nv_store <= 1'b0;
        sp_pending_r <= 1'b1;
      end
      else if (cmd_rise[`CMD_SP_EN] && sp_pending_r)
      begin
        o_nv_store <= 1'b1; // R14
        sp_pending_r <= 1'b0;
      end
      else
        o_nv_store <= 1'b0;
    end
  end

  // ************************************
  // parallel outputs
  // ************************************
  // outside indicator mode the outputs keep their last state
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      {o_parallel_output_three, o_parallel_output_two, o_parallel_output_one} <= `PAR_RESET;
    else if (cmd_wr && i_indicator_mode) // R18
      {o_parallel_output_three, o_parallel_output_two, o_parallel_output_one} <=
        i_wdata[`CMD_PAR_HI:`CMD_PAR_LO]; // R17
  end

  // ************************************
  // input word composition
  // ************************************
  assign tare_or_target = i_overunder_mode ? i_target : i_tare;
  assign data_ok = i_scale_normal && !i_over_range && !i_under_range && !i_power_up && !i_expanded
    && !i_setup; // R5
  assign weight_word = data_ok ? pick_weight(cmd_r[`CMD_SEL_HI:`CMD_SEL_LO], i_gross, i_net, i_displayed,
    tare_or_target, i_setpoint1) : 16'h0000; // R10 R5
  assign sp1_bit = i_overunder_mode ? i_under_ind : i_sp1_out; // R6
  assign sp2_bit = i_overunder_mode ? i_ok_ind : i_sp2_out; // R7
  assign ztol_bit = i_overunder_mode ? i_over_ind : i_ztol_out; // R8

  // status bits at their fixed places, unused bits zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`STS_SP1] = sp1_bit; // R2
    status_word[`STS_SP2] = sp2_bit;
    status_word[`STS_ZTOL] = ztol_bit;
    status_word[`STS_PAR_IN] = par_sync_r;
    status_word[`STS_MOTION] = i_motion;
    status_word[`STS_NET] = i_net_mode;
    status_word[`STS_DATA_OK] = data_ok; // R5
  end

  // ************************************
  // refresh sequencer
  // ************************************
  // words go in one per cycle, so a read can see a torn pair
  always_comb
  begin
    ref_state_nxt = ref_state_r;
    unique case (ref_state_r)
      scale_xchg_pkg::REF_IDLE:
        if (i_refresh)
          ref_state_nxt = scale_xchg_pkg::REF_WORD0;
      scale_xchg_pkg::REF_WORD0:
        ref_state_nxt = scale_xchg_pkg::REF_WORD1;
      scale_xchg_pkg::REF_WORD1:
        ref_state_nxt = scale_xchg_pkg::REF_IDLE;
      default:
        ref_state_nxt = scale_xchg_pkg::REF_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ref_state_r <= scale_xchg_pkg::REF_IDLE;
    else
      ref_state_r <= ref_state_nxt;
  end

  // snapshot both words together so the pair is coherent
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      weight_latch_r <= `WORD_RESET;
      status_latch_r <= `WORD_RESET;
    end
    else if (ref_state_r == scale_xchg_pkg::REF_IDLE && i_refresh)
    begin
      weight_latch_r <= weight_word;
      status_latch_r <= status_word;
    end
  end

  assign busy = ref_state_r != scale_xchg_pkg::REF_IDLE;

  // ************************************
  // update-in-progress flag
  // ************************************
  // set by a read during rewrite or a rewrite between the two reads;
  // cleared by the status read, and a new set wins over that clear
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      uip_r <= 1'b0;
      rd0_seen_r <= 1'b0;
    end
    else
    begin
      if ((i_rd && busy) || (busy && rd0_seen_r))
        uip_r <= 1'b1; // R3
      else if (i_rd && i_addr == `XCHG_ADDR_STATUS)
        uip_r <= 1'b0; // R4
      if (i_rd && i_addr == `XCHG_ADDR_WEIGHT)
        rd0_seen_r <= 1'b1;
      else if (i_rd && i_addr == `XCHG_ADDR_STATUS)
        rd0_seen_r <= 1'b0;
    end
  end

  // ************************************
  // memory port wiring
  // ************************************
  assign mbus.dev_we = busy;
  assign mbus.dev_addr = (ref_state_r == scale_xchg_pkg::REF_WORD0) ? `XCHG_ADDR_WEIGHT : `XCHG_ADDR_STATUS;
  assign mbus.dev_wdata = (ref_state_r == scale_xchg_pkg::REF_WORD0) ? weight_latch_r : status_latch_r;
  assign mbus.plc_we = i_wr && i_addr[1]; // only output words are writable
  assign mbus.plc_addr = i_addr;
  assign mbus.plc_wdata = i_wdata;
  assign mbus.rd = i_rd;
  assign mbus.rd_addr = i_addr;
  // status answer carries the flag, including a read landing mid-rewrite
  assign mbus.rd_or = (i_addr == `XCHG_ADDR_STATUS && (uip_r || busy)) ? (16'h0001 << `STS_UIP) : 16'h0000; // R3
  assign o_rdata = mbus.rdata;
endmodule : scale_xchg

// [scale_xchg_cfg.svh]
// constants for the per-scale discrete exchange block
// Notes on behaviour
// R1: two 16-bit words each way per scale
// R2: status bits 0,1,2,9,12,13,14,15 fixed
// R3: flag update-in-progress when read meets rewrite
// R4: controller rereads words flagged update-in-progress
// R5: data-ok only when normal; else weight zero
// R6: status bit0 is setpoint1 or under
// R7: status bit1 is setpoint2 or ok band
// R8: status bit2 is zero tolerance or over
// R9: output word0 holds tare or setpoint value
// R10: command bits 0-2 select reported weight
// R11: bit3 rising copies word0 to preset tare
// R12: bits 4-7 rising: clear, tare, print, zero
// R13: bit8 enables setpoint high-level outputs
// R14: bit8 rising after download commits non-volatile
// R15: bit15 rising loads setpoint 1 value
// R16: setpoint value is in calibrated unit
// R17: bits 12-14 drive three parallel outputs
// R18: parallel outputs follow only in indicator mode
// R19: interlock rejects tare while tare active
// R20: interlock allows clear tare only at zero
// R21: command bits 9-11 are ignored
// R22: command edges found against previous word
`ifndef SCALE_XCHG_CFG_SVH
`define SCALE_XCHG_CFG_SVH
// ************************************
// shared word addresses
// ************************************
`define XCHG_ADDR_WEIGHT 2'h0
`define XCHG_ADDR_STATUS 2'h1
`define XCHG_ADDR_VALUE 2'h2
`define XCHG_ADDR_CMD 2'h3
// ************************************
// status word bit positions
// ************************************
`define STS_SP1 0
`define STS_SP2 1
`define STS_ZTOL 2
`define STS_PAR_IN 9
`define STS_MOTION 12
`define STS_NET 13
`define STS_UIP 14
`define STS_DATA_OK 15
// ************************************
// command word bit positions
// ************************************
`define CMD_SEL_LO 0
`define CMD_SEL_HI 2
`define CMD_PRESET 3
`define CMD_CLR_TARE 4
`define CMD_PB_TARE 5
`define CMD_PRINT 6
`define CMD_ZERO 7
`define CMD_SP_EN 8
`define CMD_PAR_LO 12
`define CMD_PAR_HI 14
`define CMD_LOAD_SP1 15
// ************************************
// weight source codes and reset values
// ************************************
`define SEL_GROSS 3'h0
`define SEL_NET 3'h1
`define SEL_DISP 3'h2
`define SEL_TARE 3'h3
`define SEL_SP1 3'h4
`define WORD_RESET 16'h0000
`define PAR_RESET 3'h0
`endif

// [scale_xchg_chk.sv]
// port assertions for the per-scale exchange block
`timescale 1ns/10ps
module scale_xchg_chk
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic i_indicator_mode,
  input wire logic i_tare_interlock,
  input wire logic i_tare_active,
  input wire logic i_gross_zero,
  input wire logic o_preset_tare_load,
  input wire logic [15:0] o_preset_tare,
  input wire logic o_clear_tare,
  input wire logic o_pb_tare,
  input wire logic o_print,
  input wire logic o_zero,
  input wire logic o_setpoint_enable,
  input wire logic o_sp1_load,
  input wire logic [15:0] o_sp1_value,
  input wire logic o_nv_store,
  input wire logic o_parallel_output_one,
  input wire logic o_parallel_output_two,
  input wire logic o_parallel_output_three
);
  // ****************
  // reference copies
  // ****************
  logic [15:0] cmd_r; // last command word, the edge reference
  logic [15:0] val_r; // last value word
  logic cw; // command word write this cycle
  logic [2:0] par; // parallel outputs as one field
  assign cw = i_wr && i_addr == 2'h3;
  assign par = {o_parallel_output_three, o_parallel_output_two, o_parallel_output_one};
  // command copy clears with reset so the first write compares to zero
  always_ff @(posedge i_clk)
    if (i_reset)
      cmd_r <= 16'h0000;
    else if (cw)
      cmd_r <= i_wdata;
  // value copy
  always_ff @(posedge i_clk)
    if (i_reset)
      val_r <= 16'h0000;
    else if (i_wr && i_addr == 2'h2)
      val_r <= i_wdata;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ****************
  // assertions
  // ****************
  a_zero_edge: assert property (
    o_zero == $past(cw && i_wdata[7] && !cmd_r[7])) else $error("zero pulse mismatch");
  a_print_edge: assert property (
    o_print == $past(cw && i_wdata[6] && !cmd_r[6])) else $error("print pulse mismatch");
  a_tare_lock: assert property (
    o_pb_tare == $past(cw && i_wdata[5] && !cmd_r[5] && !(i_tare_interlock && i_tare_active)))
    else $error("tare pulse mismatch");
  a_clear_lock: assert property (
    o_clear_tare == $past(cw && i_wdata[4] && !cmd_r[4] && !(i_tare_interlock && !i_gross_zero)))
    else $error("clear tare pulse mismatch");
  a_preset_copy: assert property (
    (cw && i_wdata[3] && !cmd_r[3] && !(i_tare_interlock && i_tare_active))
    |=> o_preset_tare_load && o_preset_tare == $past(val_r)) else $error("preset tare mismatch");
  a_sp1_load: assert property (
    (cw && i_wdata[15] && !cmd_r[15]) |=> o_sp1_load && o_sp1_value == $past(val_r))
    else $error("setpoint load mismatch");
  a_nv_with_enable: assert property (
    o_sp1_load && o_setpoint_enable |-> o_nv_store) else $error("store missing");
  a_enable_follow: assert property (
    o_setpoint_enable == cmd_r[8]) else $error("setpoint enable mismatch");
  a_par_load: assert property (
    cw && i_indicator_mode |=> par == $past(i_wdata[14:12])) else $error("parallel output mismatch");
  a_par_hold: assert property (
    !$past(cw && i_indicator_mode) |-> $stable(par)) else $error("parallel output moved");
  a_read_idle: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data outside answer cycle");
  c_nv: cover property (o_nv_store);
  c_tare: cover property (o_pb_tare);
  c_clear: cover property (o_clear_tare && i_tare_interlock);
endmodule : scale_xchg_chk
bind scale_xchg scale_xchg_chk scale_xchg_chk_i (.*);

// [scale_xchg_pkg.sv]
// types shared by the exchange block
package scale_xchg_pkg;
  // refresh sequencer states, one-hot
  typedef enum logic [2:0]
  {
    REF_IDLE = 3'h1,
    REF_WORD0 = 3'h2,
    REF_WORD1 = 3'h4
  } refresh_state_t;
  typedef logic [15:0] word_t;
endpackage : scale_xchg_pkg

// [shared_mem_if.sv]
// carrier between the exchange core and its shared word memory
`timescale 1ns/10ps
interface shared_mem_if;
  logic dev_we; // device writes an input word
  logic [1:0] dev_addr;
  logic [15:0] dev_wdata;
  logic plc_we; // controller writes an output word
  logic [1:0] plc_addr;
  logic [15:0] plc_wdata;
  logic rd; // controller read strobe
  logic [1:0] rd_addr;
  logic [15:0] rd_or; // bits forced high into the read answer
  logic [15:0] rdata; // registered read answer
  modport core
  (
    output dev_we, dev_addr, dev_wdata, plc_we, plc_addr, plc_wdata, rd, rd_addr, rd_or,
    input rdata
  );
  modport mem
  (
    input dev_we, dev_addr, dev_wdata, plc_we, plc_addr, plc_wdata, rd, rd_addr, rd_or,
    output rdata
  );
endinterface : shared_mem_if

// [shared_word_mem.sv]
// four-word shared memory with a registered read answer
`timescale 1ns/10ps
`include "scale_xchg_cfg.svh"
module shared_word_mem
(
  input wire logic i_clk,
  input wire logic i_reset,
  shared_mem_if.mem bus
);
  // ************************************
  // storage
  // ************************************
  logic [15:0] mem_r [4]; // the four exchanged words
  logic [15:0] rdata_r; // answer register

  // both write ports; the core keeps them on distinct addresses
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_word
      always_ff @(posedge i_clk)
      begin
        if (i_reset)
          mem_r[g] <= `WORD_RESET;
        else if (bus.dev_we && bus.dev_addr == 2'(g))
          mem_r[g] <= bus.dev_wdata;
        else if (bus.plc_we && bus.plc_addr == 2'(g))
          mem_r[g] <= bus.plc_wdata;
      end
    end
  endgenerate

  // answer stands only in the cycle after the read strobe
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      rdata_r <= `WORD_RESET;
    else if (bus.rd)
      rdata_r <= mem_r[bus.rd_addr] | bus.rd_or;
    else
      rdata_r <= `WORD_RESET;
  end

  assign bus.rdata = rdata_r;
endmodule : shared_word_mem

// [tb.sv]
// self-checking bench for the exchange block
`timescale 1ns/10ps
module tb;
  logic i_clk, i_reset, i_refresh, ind;
  logic [15:0] i_gross, i_net, i_displayed, i_tare, i_target, i_setpoint1, cmd, w, s;
  logic i_scale_normal, i_over_range, i_under_range, i_power_up, i_expanded, i_setup;
  logic i_motion, i_net_mode, i_overunder_mode, i_indicator_mode, i_parallel_input_state;
  logic i_tare_interlock, i_tare_active, i_gross_zero;
  logic i_sp1_out, i_sp2_out, i_ztol_out, i_under_ind, i_ok_ind, i_over_ind;
  wire [1:0] i_addr;
  wire [15:0] i_wdata, o_rdata, o_preset_tare, o_sp1_value;
  wire i_wr, i_rd, o_preset_tare_load, o_clear_tare, o_pb_tare, o_print, o_zero;
  wire o_setpoint_enable, o_sp1_load, o_nv_store;
  wire o_parallel_output_one, o_parallel_output_two, o_parallel_output_three;
  logic [2:0] par_exp; // expected parallel outputs
  int seed = 32'hc27c;
  int err_count = 0;
  int compares = 0;
  wire [6:0] pulses = {o_preset_tare_load, o_clear_tare, o_pb_tare, o_print, o_zero, o_sp1_load, o_nv_store};
  wire [2:0] par = {o_parallel_output_three, o_parallel_output_two, o_parallel_output_one};
  scale_xchg scale_xchg_i (.*);
  plc_model plc_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  function automatic logic data_ok();
    return i_scale_normal && !(i_over_range || i_under_range || i_power_up || i_expanded || i_setup);
  endfunction : data_ok
  // weight the terminal should publish for a source code
  function automatic logic [15:0] exp_weight(input logic [2:0] sel);
    if (!data_ok())
      return 16'h0000;
    case (sel)
      3'h1: return i_net;
      3'h2: return i_displayed;
      3'h3: return i_overunder_mode ? i_target : i_tare;
      3'h4: return i_setpoint1;
      default: return i_gross;
    endcase
  endfunction : exp_weight
  // settled status word, no update in progress
  function automatic logic [15:0] exp_status();
    logic ou;
    ou = i_overunder_mode;
    return {data_ok(), 1'b0, i_net_mode, i_motion, 2'h0, i_parallel_input_state, 6'h00,
      ou ? i_over_ind : i_ztol_out, ou ? i_ok_ind : i_sp2_out, ou ? i_under_ind : i_sp1_out};
  endfunction : exp_status
  task automatic rand_inputs(output logic ind_o);
    logic [15:0] r;
    r = 16'($random(seed));
    ind_o = r[10];
    i_indicator_mode <= r[10];
    {i_motion, i_net_mode, i_overunder_mode, i_sp1_out, i_sp2_out, i_ztol_out, i_under_ind, i_ok_ind,
      i_over_ind, i_parallel_input_state} <= r[9:0];
    i_gross <= 16'($random(seed));
    i_net <= 16'($random(seed));
    i_displayed <= 16'($random(seed));
    i_tare <= 16'($random(seed));
    i_target <= 16'($random(seed));
    i_setpoint1 <= 16'($random(seed));
  endtask : rand_inputs
  // input pins settle past the synchroniser, then a two-cycle rewrite
  task automatic refresh();
    repeat (3) @(posedge i_clk);
    i_refresh <= 1'b1;
    @(posedge i_clk);
    i_refresh <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : refresh
  // command write, then the pulse cycle and the quiet cycle after it
  task automatic cmd_pulse(input logic [15:0] c, input logic [6:0] exp);
    plc_model_i.write_word(2'h3, c);
    check({9'h000, pulses}, {9'h000, exp});
    @(posedge i_clk);
    #1;
    check({9'h000, pulses}, 16'h0000);
  endtask : cmd_pulse
  // ****************
  // clock, watchdog, sequence
  // ****************
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // well beyond the few hundred cycles the sequence needs
  initial
  begin
    #(20000 * 50);
    err_count++;
    final_report();
  end
  initial
  begin
    i_reset = 1'b1;
    {i_refresh, i_over_range, i_under_range, i_power_up, i_expanded, i_setup} = 6'h00;
    {i_tare_interlock, i_tare_active, i_gross_zero} = 3'h0;
    i_scale_normal = 1'b1;
    par_exp = 3'h0;
    rand_inputs(ind);
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    // every source code, random flags, modes and parallel control
    for (int k = 0; k < 24; k++)
    begin
      rand_inputs(ind);
      cmd = 16'($random(seed));
      cmd[7:0] = {5'h00, k[2:0]};
      cmd[15] = 1'b0;
      plc_model_i.write_word(2'h3, cmd);
      if (ind)
        par_exp = cmd[14:12];
      refresh();
      plc_model_i.read_pair(w, s);
      check(w, exp_weight(cmd[2:0]));
      check(s, exp_status());
      check({13'h0000, par}, {13'h0000, par_exp});
      check({15'h0000, o_setpoint_enable}, {15'h0000, cmd[8]});
    end
    // each abnormal scale state forces zero weight and clears data ok
    for (int f = 0; f < 6; f++)
    begin
      {i_scale_normal, i_over_range, i_under_range, i_power_up, i_expanded, i_setup} <= 6'h20 ^ (6'h20 >> f);
      refresh();
      plc_model_i.read_pair(w, s);
      check(w, 16'h0000);
      check(s, exp_status());
    end
    i_scale_normal <= 1'b1;
    i_setup <= 1'b0;
    // a rewrite between weight and status read must be flagged once
    plc_model_i.read_word(2'h0, w);
    refresh();
    plc_model_i.read_word(2'h1, s);
    check({15'h0000, s[14]}, 16'h0001);
    plc_model_i.read_word(2'h1, s);
    check({15'h0000, s[14]}, 16'h0000);
    // edge commands fire once, a held bit stays quiet
    cmd_pulse(16'h0000, 7'h00);
    for (int b = 4; b < 8; b++)
    begin
      cmd_pulse(16'h0001 << b, 7'h01 << (9 - b));
      cmd_pulse(16'h0001 << b, 7'h00);
      cmd_pulse(16'h0000, 7'h00);
    end
    plc_model_i.write_word(2'h2, 16'hA5C3);
    cmd_pulse(16'h0008, 7'h40);
    check(o_preset_tare, 16'hA5C3);
    cmd_pulse(16'h0000, 7'h00);
    // interlocked tare and clear
    {i_tare_interlock, i_tare_active, i_gross_zero} <= 3'h6;
    cmd_pulse(16'h0020, 7'h00);
    cmd_pulse(16'h0010, 7'h00);
    cmd_pulse(16'h0000, 7'h00);
    i_gross_zero <= 1'b1;
    cmd_pulse(16'h0010, 7'h20);
    cmd_pulse(16'h0000, 7'h00);
    i_tare_interlock <= 1'b0;
    // setpoint load without store, store on later enable, then both at once
    plc_model_i.write_word(2'h2, 16'h7FFE);
    cmd_pulse(16'h8000, 7'h02);
    check(o_sp1_value, 16'h7FFE);
    cmd_pulse(16'h8100, 7'h01);
    cmd_pulse(16'h0000, 7'h00);
    plc_model_i.write_word(2'h2, 16'h8001);
    cmd_pulse(16'h8100, 7'h03);
    check(o_sp1_value, 16'h8001);
    final_report();
  end
endmodule : tb
